// ---- design/scb_ctrl.sv ----
// Purpose: Command handling and cell balance control of one stack device
// Assumes: Commands arrive decoded, CRC checked, one cycle per command
// Notes:   Balance outputs gate the FET drivers directly
// Operation
// - Master drives 4 kHz wake tone on chain after wake command
// - Soft reset: defaults, halt balancing, wait packet timeout, then reset
// - Checksum calculate sums control registers and stores result
// - Checksum check recomputes and compares with stored value
// - All-ones write clears faults; after override, one verbatim load
// - Prefix to master address acknowledged and next command trapped; else NAK
// - Trapped command other than wake or hard reset gets NAK, no tone
// - Hard reset: master emits 32 kHz tone, devices fully reset
// - Hard reset with non-all address answered NAK
// - Prefix ACK when awake, silent asleep, NAK and refuse before roll call
// - Wake to all gets top reply only; targeted wake gets NAK
// - Internal select bit: 0 external, 1 internal balancing
// - Scan-disable bit stops balancing during continuous cell scan
// - Run bit set by register write or balance enable command
// - Mode field: 00 off, 01 manual, 10 timed, 11 auto
// - Wait between cycles is two to the power n minus one
// - Manual and timed use first pattern; auto steps fourteen patterns
// - On-time is code times 20 s, timed and auto only
// - Auto cycle is on-time plus wait; values count cycles per cell
// - Time code zero disables timed duration
`timescale 1ns/1ps
`include "scb_params.svh"
module scb_ctrl #(
  parameter int unsigned SEC_CYCLES = 100000000,
  parameter int unsigned WAKE_HALF_CYCLES = 12500,
  parameter int unsigned HRST_HALF_CYCLES = 1562,
  parameter int unsigned TONE_EDGES = 32,
  parameter int unsigned PKT_TIMEOUT_CYCLES = 100000
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [5:0] cmd_addr,
  input wire logic is_master,
  input wire logic is_top,
  input wire logic awake,
  input wire logic addr_assigned,
  input wire logic reg_wr,
  input wire logic [2:0] reg_sel,
  input wire logic [3:0] reg_idx,
  input wire logic [15:0] reg_wdata,
  input wire logic [7:0] fault_set,
  input wire logic scan_cont_active,
  input wire logic cell_scan_active,
  output logic rsp_ack,
  output logic rsp_nak,
  output logic chain_tone,
  output logic hard_reset_req,
  output logic soft_reset_done,
  output logic csum_mismatch,
  output logic [8:0] balance_setup,
  output logic [13:0] balance_cell_pattern,
  output logic [14:0] watchdog_balance_time,
  output logic [7:0] fault_reg,
  output logic [13:0] bal_ext_drive,
  output logic [13:0] bal_int_drive
);
  // ==========================================================
  // Declarations
  logic trap_q;
  logic refuse_q;
  logic override_q;
  logic [15:0] csum_q;
  logic tone_on_q;
  scb_pkg::scb_tone_t tone_q;
  logic [13:0] tone_cnt_q;
  logic [5:0] tone_edges_q;
  logic softrst_pend_q;
  logic [16:0] softrst_cnt_q;
  logic soft_clr;
  logic [13:0] pat_q [0:13];
  logic [7:0] val_q [0:13];
  scb_pkg::scb_bal_state_t bal_q;
  logic [3:0] pat_idx_q;
  logic [26:0] sec_cnt_q;
  logic [12:0] secs_q;
  logic sec_tick;
  logic [1:0] mode;
  logic [13:0] sel_cells;
  logic [12:0] on_secs;
  logic [12:0] wait_secs;
  logic all_zero;
  logic timed_dur;
  logic cmd_bal_en;
  logic cmd_bal_inh;
  logic bal_finish;

  // Checksum over all control registers
  function automatic logic [15:0] scb_csum(input logic [8:0] s, input logic [14:0] t,
                                           input logic [13:0] p0, input logic [13:0] p1);
    scb_csum = {7'h00, s} + {1'b0, t} + {2'h0, p0} + {2'h0, p1};
  endfunction : scb_csum

  function automatic logic [15:0] scb_csum_all();
    logic [15:0] acc;
    acc = scb_csum(balance_setup, watchdog_balance_time, 14'h0000, 14'h0000);
    for (int i = 0; i < `SCB_CELLS; i++) begin
      acc = acc + {2'h0, pat_q[i]} + {8'h00, val_q[i]};
    end
    scb_csum_all = acc;
  endfunction : scb_csum_all

  assign soft_clr = softrst_pend_q && (softrst_cnt_q == 17'h00000);
  assign cmd_bal_en = cmd_valid && !trap_q && (cmd_code == `SCB_CMD_BAL_EN);
  assign cmd_bal_inh = cmd_valid && !trap_q && (cmd_code == `SCB_CMD_BAL_INH);

  // ==========================================================
  // Command responses and precursor trap
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      trap_q <= 1'b0;
      refuse_q <= 1'b0;
      rsp_ack <= 1'b0;
      rsp_nak <= 1'b0;
    end else begin
      rsp_ack <= 1'b0;
      rsp_nak <= 1'b0;
      if (cmd_valid && trap_q) begin
        trap_q <= 1'b0;
        if ((cmd_code == `SCB_CMD_WAKE) && !refuse_q) begin
          rsp_ack <= is_top && (cmd_addr == `SCB_ADDR_ALL);
          rsp_nak <= (cmd_addr != `SCB_ADDR_ALL);
        end else if ((cmd_code == `SCB_CMD_HARDRST) && !refuse_q) begin
          rsp_nak <= (cmd_addr != `SCB_ADDR_ALL);
        end else begin
          rsp_nak <= 1'b1;
        end
        refuse_q <= 1'b0;
      end else if (cmd_valid && is_master && (cmd_code == `SCB_CMD_PREFIX)) begin
        if (cmd_addr != `SCB_ADDR_MASTER) begin
          rsp_nak <= 1'b1;
        end else if (!addr_assigned) begin
          rsp_nak <= 1'b1;
          refuse_q <= 1'b1;
          trap_q <= 1'b1;
        end else if (awake) begin
          rsp_ack <= 1'b1;
          trap_q <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Chain tone generator; the tone is a fixed burst of edges
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tone_on_q <= 1'b0;
      tone_q <= scb_pkg::SCB_TONE_NONE;
      tone_cnt_q <= 14'h0000;
      tone_edges_q <= 6'h00;
      chain_tone <= 1'b0;
      hard_reset_req <= 1'b0;
    end else begin
      if (cmd_valid && trap_q && !refuse_q && (cmd_addr == `SCB_ADDR_ALL) &&
          ((cmd_code == `SCB_CMD_WAKE) || (cmd_code == `SCB_CMD_HARDRST))) begin
        tone_on_q <= 1'b1;
        tone_q <= (cmd_code == `SCB_CMD_WAKE) ? scb_pkg::SCB_TONE_WAKE
                                              : scb_pkg::SCB_TONE_NONE;
        tone_cnt_q <= 14'h0000;
        tone_edges_q <= 6'h00;
      end else if (tone_on_q) begin
        if (tone_cnt_q == ((tone_q == scb_pkg::SCB_TONE_WAKE) ?
                           14'(WAKE_HALF_CYCLES - 1) : 14'(HRST_HALF_CYCLES - 1))) begin
          tone_cnt_q <= 14'h0000;
          chain_tone <= !chain_tone;
          tone_edges_q <= tone_edges_q + 6'h01;
          if (tone_edges_q == 6'(TONE_EDGES - 1)) begin
            tone_on_q <= 1'b0;
            hard_reset_req <= (tone_q != scb_pkg::SCB_TONE_WAKE);
          end
        end else begin
          tone_cnt_q <= tone_cnt_q + 14'h0001;
        end
      end
    end
  end

  // ==========================================================
  // Soft reset: wait out the packet timeout, then clear
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      softrst_pend_q <= 1'b0;
      softrst_cnt_q <= 17'h00000;
      soft_reset_done <= 1'b0;
    end else begin
      soft_reset_done <= soft_clr;
      if (cmd_valid && !trap_q && (cmd_code == `SCB_CMD_SOFTRST) &&
          (cmd_addr == `SCB_ADDR_ALL)) begin
        softrst_pend_q <= 1'b1;
        softrst_cnt_q <= 17'(PKT_TIMEOUT_CYCLES - 1);
      end else if (soft_clr) begin
        softrst_pend_q <= 1'b0;
      end else if (softrst_pend_q) begin
        softrst_cnt_q <= softrst_cnt_q - 17'h00001;
      end
    end
  end

  // ==========================================================
  // Checksum store and compare
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      csum_q <= 16'h0000;
      csum_mismatch <= 1'b0;
    end else if (soft_clr) begin
      csum_q <= 16'h0000;
      csum_mismatch <= 1'b0;
    end else if (cmd_valid && !trap_q && (cmd_code == `SCB_CMD_CSUM_CALC)) begin
      csum_q <= scb_csum_all();
    end else if (cmd_valid && !trap_q && (cmd_code == `SCB_CMD_CSUM_CHECK)) begin
      csum_mismatch <= (scb_csum_all() != csum_q);
    end
  end

  // ==========================================================
  // Fault register; a new fault wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      override_q <= 1'b0;
      fault_reg <= `SCB_FAULT_RST;
    end else if (soft_clr) begin
      override_q <= 1'b0;
      fault_reg <= `SCB_FAULT_RST;
    end else begin
      if (cmd_valid && !trap_q && (cmd_code == `SCB_CMD_OVERRIDE)) begin
        override_q <= 1'b1;
      end else if (reg_wr) begin
        override_q <= 1'b0;
      end
      if (reg_wr && (reg_sel == `SCB_SEL_FAULT) && override_q) begin
        fault_reg <= (reg_wdata[7:0] & ~`SCB_FLT_PROT) |
                     (fault_reg & `SCB_FLT_PROT) | fault_set;
      end else if (reg_wr && (reg_sel == `SCB_SEL_FAULT) &&
                   (reg_wdata[7:0] == `SCB_FLT_ONES)) begin
        fault_reg <= fault_set;
      end else begin
        fault_reg <= fault_reg | fault_set;
      end
    end
  end

  // ==========================================================
  // Balance setup register: run bit from write, command or sequencer
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      balance_setup <= `SCB_SETUP_RST;
    end else if (soft_clr || (cmd_valid && !trap_q && (cmd_code == `SCB_CMD_SOFTRST) &&
                              (cmd_addr == `SCB_ADDR_ALL))) begin
      balance_setup <= `SCB_SETUP_RST;
    end else begin
      if (reg_wr && (reg_sel == `SCB_SEL_SETUP)) begin
        balance_setup <= reg_wdata[8:0];
      end
      if (cmd_bal_en) begin
        balance_setup[`SCB_B_RUN] <= 1'b1;
      end else if (cmd_bal_inh) begin
        balance_setup[`SCB_B_RUN] <= 1'b0;
      end
      if (bal_finish) begin
        balance_setup[`SCB_B_RUN] <= 1'b0;
        balance_setup[`SCB_B_DONE] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Time register, pattern and value tables
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      watchdog_balance_time <= `SCB_TIME_RST;
      for (int i = 0; i < `SCB_CELLS; i++) begin
        pat_q[i] <= `SCB_PAT_RST;
        val_q[i] <= 8'h00;
      end
    end else if (soft_clr) begin
      watchdog_balance_time <= `SCB_TIME_RST;
      for (int i = 0; i < `SCB_CELLS; i++) begin
        pat_q[i] <= `SCB_PAT_RST;
        val_q[i] <= 8'h00;
      end
    end else begin
      if (reg_wr && (reg_sel == `SCB_SEL_TIME)) begin
        watchdog_balance_time <= reg_wdata[14:0];
      end
      if (reg_wr && (reg_sel == `SCB_SEL_PATTERN) && (reg_idx <= `SCB_LAST_PAT)) begin
        pat_q[reg_idx] <= reg_wdata[13:0];
      end
      for (int i = 0; i < `SCB_CELLS; i++) begin
        if (reg_wr && (reg_sel == `SCB_SEL_VALUE) && (reg_idx == 4'(i))) begin
          val_q[i] <= reg_wdata[7:0];
        end else if ((bal_q == scb_pkg::SCB_BAL_ON) && (mode == `SCB_MODE_AUTO) &&
                     sec_tick && (secs_q == on_secs) && pat_q[pat_idx_q][i] &&
                     (val_q[i] != 8'h00)) begin
          val_q[i] <= val_q[i] - 8'h01;
        end
      end
    end
  end
  assign balance_cell_pattern = pat_q[0];

  // ==========================================================
  // Balance timing decode
  assign mode = balance_setup[`SCB_B_MODE_LO +: 2];
  assign on_secs = 13'(watchdog_balance_time[`SCB_B_TIME_LO +: 7] * `SCB_STEP_SEC -
                       13'h0001);
  // Code zero waits a second; a half second is not representable
  assign wait_secs = (balance_setup[`SCB_B_WAIT_LO +: 3] == 3'h0) ? 13'h0000 :
                     13'(13'h0001 << (balance_setup[`SCB_B_WAIT_LO +: 3] - 3'h1)) -
                     13'h0001;
  assign timed_dur = (watchdog_balance_time[`SCB_B_TIME_LO +: 7] != 7'h00);
  assign sec_tick = (sec_cnt_q == 27'(SEC_CYCLES - 1));
  always_comb begin
    all_zero = 1'b1;
    for (int i = 0; i < `SCB_CELLS; i++) begin
      if (val_q[i] != 8'h00) begin
        all_zero = 1'b0;
      end
    end
  end
  assign bal_finish = sec_tick && (((bal_q == scb_pkg::SCB_BAL_ON) && (mode == `SCB_MODE_TIMED)
                      && timed_dur && (secs_q == on_secs)) ||
                      ((bal_q == scb_pkg::SCB_BAL_WAIT) && (mode == `SCB_MODE_AUTO) &&
                      all_zero && (secs_q == wait_secs)));

  // ==========================================================
  // Balance sequencer with one second time base
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bal_q <= scb_pkg::SCB_BAL_IDLE;
      pat_idx_q <= 4'h0;
      sec_cnt_q <= 27'h0000000;
      secs_q <= 13'h0000;
    end else begin
      sec_cnt_q <= sec_tick ? 27'h0000000 : sec_cnt_q + 27'h0000001;
      if (!balance_setup[`SCB_B_RUN] || (mode == `SCB_MODE_OFF) || bal_finish) begin
        bal_q <= scb_pkg::SCB_BAL_IDLE;
        pat_idx_q <= 4'h0;
      end else begin
        unique case (bal_q)
          scb_pkg::SCB_BAL_IDLE: begin
            bal_q <= scb_pkg::SCB_BAL_ON;
            secs_q <= 13'h0000;
            sec_cnt_q <= 27'h0000000;
          end
          scb_pkg::SCB_BAL_ON: begin
            if (sec_tick && (mode == `SCB_MODE_AUTO) && (secs_q == on_secs)) begin
              bal_q <= scb_pkg::SCB_BAL_WAIT;
              secs_q <= 13'h0000;
            end else if (sec_tick) begin
              secs_q <= secs_q + 13'h0001;
            end
          end
          scb_pkg::SCB_BAL_WAIT: begin
            if (sec_tick && (secs_q == wait_secs)) begin
              bal_q <= scb_pkg::SCB_BAL_ON;
              secs_q <= 13'h0000;
              pat_idx_q <= (pat_idx_q == `SCB_LAST_PAT) ? 4'h0 : pat_idx_q + 4'h1;
            end else if (sec_tick) begin
              secs_q <= secs_q + 13'h0001;
            end
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Cell drive: pattern choice, scan blanking, internal/external split
  always_comb begin
    sel_cells = (mode == `SCB_MODE_AUTO) ? pat_q[pat_idx_q] : pat_q[0];
    if (mode == `SCB_MODE_AUTO) begin
      for (int i = 0; i < `SCB_CELLS; i++) begin
        if (val_q[i] == 8'h00) begin
          sel_cells[i] = 1'b0;
        end
      end
    end
    if ((bal_q != scb_pkg::SCB_BAL_ON) ||
        (balance_setup[`SCB_B_SCAN_DIS] && scan_cont_active && cell_scan_active)) begin
      sel_cells = 14'h0000;
    end
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bal_ext_drive <= 14'h0000;
      bal_int_drive <= 14'h0000;
    end else begin
      bal_ext_drive <= balance_setup[`SCB_B_INT_SEL] ? 14'h0000 : sel_cells;
      bal_int_drive <= balance_setup[`SCB_B_INT_SEL] ? sel_cells : 14'h0000;
    end
  end

  // ==========================================================
  // Assertions
  a_prefix_bad_addr: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmd_valid && !trap_q && is_master && (cmd_code == `SCB_CMD_PREFIX) &&
    (cmd_addr != `SCB_ADDR_MASTER) |=> rsp_nak && !trap_q) else $error("prefix nak");
  a_prefix_ack_trap: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmd_valid && !trap_q && is_master && (cmd_code == `SCB_CMD_PREFIX) &&
    (cmd_addr == `SCB_ADDR_MASTER) && addr_assigned && awake |=> rsp_ack && trap_q)
    else $error("prefix ack");
  a_trap_one_cmd: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmd_valid && trap_q |=> !trap_q) else $error("trap kept");
  a_trap_bad_cmd: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmd_valid && trap_q && (cmd_code != `SCB_CMD_WAKE) && (cmd_code != `SCB_CMD_HARDRST)
    && !tone_on_q |=> rsp_nak && !tone_on_q) else $error("bad trapped cmd");
  a_hrst_addr_nak: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmd_valid && trap_q && (cmd_code == `SCB_CMD_HARDRST) && (cmd_addr != `SCB_ADDR_ALL)
    |=> rsp_nak) else $error("hrst nak");
  a_run_by_cmd: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmd_bal_en && !soft_clr && !bal_finish && !(cmd_code == `SCB_CMD_SOFTRST)
    |=> balance_setup[`SCB_B_RUN]) else $error("run not set");
  a_int_ext_split: assert property (@(posedge clk_sys) disable iff (!resetn)
    (bal_ext_drive & bal_int_drive) == 14'h0000) else $error("both drives");
  a_scan_blank: assert property (@(posedge clk_sys) disable iff (!resetn)
    balance_setup[`SCB_B_SCAN_DIS] && scan_cont_active && cell_scan_active
    |=> (bal_ext_drive | bal_int_drive) == 14'h0000) else $error("scan not blanked");
  a_fault_ones: assert property (@(posedge clk_sys) disable iff (!resetn)
    reg_wr && (reg_sel == `SCB_SEL_FAULT) && !override_q && !soft_clr &&
    (reg_wdata[7:0] == `SCB_FLT_ONES) |=> fault_reg == $past(fault_set))
    else $error("fault clear");
  a_off_mode: assert property (@(posedge clk_sys) disable iff (!resetn)
    (mode == `SCB_MODE_OFF) |=> ##1 (bal_ext_drive | bal_int_drive) == 14'h0000)
    else $error("off mode drives");
  c_wake_tone: cover property (@(posedge clk_sys) disable iff (!resetn)
    tone_on_q && (tone_q == scb_pkg::SCB_TONE_WAKE));
  c_hard_reset: cover property (@(posedge clk_sys) disable iff (!resetn)
    $rose(hard_reset_req));
  c_auto_wait: cover property (@(posedge clk_sys) disable iff (!resetn)
    bal_q == scb_pkg::SCB_BAL_WAIT);
  c_soft_reset: cover property (@(posedge clk_sys) disable iff (!resetn) soft_clr);
endmodule : scb_ctrl

// ---- design/scb_params.svh ----
// Purpose: Named constants of the stack command and balance controller
// Assumes: 100 MHz clk_sys
// Notes:   Long counts are module parameters, not macros
`ifndef SCB_PARAMS_SVH
`define SCB_PARAMS_SVH
// ==========================================================
// Command codes
`define SCB_CMD_BAL_EN 8'hCA
`define SCB_CMD_BAL_INH 8'hCB
`define SCB_CMD_WAKE 8'hD5
`define SCB_CMD_SOFTRST 8'hD6
`define SCB_CMD_CSUM_CALC 8'hD7
`define SCB_CMD_CSUM_CHECK 8'hD8
`define SCB_CMD_OVERRIDE 8'hDA
`define SCB_CMD_PREFIX 8'hDE
`define SCB_CMD_HARDRST 8'hDF
// ==========================================================
// Addresses
`define SCB_ADDR_MASTER 6'h01
`define SCB_ADDR_ALL 6'h00
// ==========================================================
// Register selects
`define SCB_SEL_SETUP 3'h0
`define SCB_SEL_PATTERN 3'h1
`define SCB_SEL_TIME 3'h2
`define SCB_SEL_FAULT 3'h3
`define SCB_SEL_VALUE 3'h4
// ==========================================================
// Balance setup and time fields and reset values
`define SCB_SETUP_RST 9'h000
`define SCB_PAT_RST 14'h0000
`define SCB_TIME_RST 15'h0000
`define SCB_FAULT_RST 8'h00
`define SCB_B_MODE_LO 0
`define SCB_B_WAIT_LO 2
`define SCB_B_RUN 5
`define SCB_B_SCAN_DIS 6
`define SCB_B_DONE 7
`define SCB_B_INT_SEL 8
`define SCB_B_TIME_LO 8
// ==========================================================
// Balance modes and timing
`define SCB_MODE_OFF 2'h0
`define SCB_MODE_MANUAL 2'h1
`define SCB_MODE_TIMED 2'h2
`define SCB_MODE_AUTO 2'h3
`define SCB_STEP_SEC 13'h0014
`define SCB_CELLS 14
`define SCB_LAST_PAT 4'hD
// ==========================================================
// Fault register: flags that a verbatim load may not set, and the all-ones clear value
`define SCB_FLT_PROT 8'h3F
`define SCB_FLT_ONES 8'hFF
`endif

// ---- design/scb_pkg.sv ----
// Purpose: Types of the stack command and balance controller
// Assumes: Used with scb_params.svh
// Notes:   Types only
package scb_pkg;
  // ==========================================================
  // Balance sequencer states
  typedef enum logic [2:0] {
    SCB_BAL_IDLE = 3'b001,
    SCB_BAL_ON = 3'b010,
    SCB_BAL_WAIT = 3'b100
  } scb_bal_state_t;
  // ==========================================================
  // Chain tone kinds
  typedef enum logic [1:0] {
    SCB_TONE_NONE = 2'b01,
    SCB_TONE_WAKE = 2'b10
  } scb_tone_t;
endpackage : scb_pkg

// ---- test/scb_ctrl_test.sv ----
// Purpose: Self-checking bench of the command and balance controller
// Assumes: Short second and tone counts via parameters
// Notes:   Responses checked in order against a queue
`timescale 1ns/1ps
`include "scb_params.svh"
module scb_ctrl_test;
  logic clk_sys = 1'b0;
  logic resetn, cmd_valid, reg_wr, is_master, is_top, awake, addr_assigned;
  logic scan_cont_active, cell_scan_active, rsp_ack, rsp_nak, chain_tone;
  logic hard_reset_req, soft_reset_done, csum_mismatch, tone_p;
  logic [7:0] cmd_code, fault_set, fault_reg;
  logic [5:0] cmd_addr;
  logic [2:0] reg_sel;
  logic [3:0] reg_idx;
  logic [15:0] reg_wdata, pat;
  logic [8:0] balance_setup;
  logic [13:0] balance_cell_pattern, bal_ext_drive, bal_int_drive;
  logic [1:0] exp_q[$];
  logic [31:0] rs = 32'h3CD85ABC;
  int err_total = 0;
  int samples_checked = 0;
  int rises = 0;
  int per = 0;
  int cyc = 0;
  int last_rise = 0;
  int k;
  // ======================================
  // Design, host model and clock
  scb_ctrl #(.SEC_CYCLES(20), .WAKE_HALF_CYCLES(4), .HRST_HALF_CYCLES(2), .TONE_EDGES(4),
    .PKT_TIMEOUT_CYCLES(10)) u_dut (.clk_sys, .resetn, .cmd_valid, .cmd_code, .cmd_addr,
    .is_master, .is_top, .awake, .addr_assigned, .reg_wr, .reg_sel, .reg_idx, .reg_wdata,
    .fault_set, .scan_cont_active, .cell_scan_active, .rsp_ack, .rsp_nak, .chain_tone,
    .hard_reset_req, .soft_reset_done, .csum_mismatch, .balance_setup, .balance_cell_pattern,
    .watchdog_balance_time(), .fault_reg, .bal_ext_drive, .bal_int_drive);
  scb_host_model u_host (.clk_sys, .cmd_valid, .cmd_code, .cmd_addr, .reg_wr, .reg_sel,
    .reg_idx, .reg_wdata);
  always #5 clk_sys = ~clk_sys;
  // ======================================
  // Shared tasks
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction : xs
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Expected answer 2'b10 ack, 2'b01 nak, 0 none or not judged
  task automatic cmd(input logic [7:0] c, input logic [5:0] a, input logic [1:0] e);
    if (e != 2'h0) exp_q.push_back(e);
    u_host.send(c, a);
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : cmd
  task automatic w(input logic [2:0] s, input logic [15:0] d);
    u_host.wr(s, 4'h0, d);
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : w
  // Rises counted over a window long enough for a whole burst
  task automatic tone_chk(input int n, input int h);
    int r0;
    r0 = rises;
    repeat (80) @(posedge clk_sys);
    chk("tone rises", 16'(n), 16'(rises - r0));
    if (n > 0) chk("tone period", 16'(2 * h), 16'(per));
  endtask : tone_chk
  task automatic conclude();
    chk("pending answers", 16'h0000, 16'(exp_q.size()));
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  // ======================================
  // Answer and tone watcher; answers of unjudged commands are skipped
  always @(posedge clk_sys) begin
    if ((rsp_ack === 1'b1 || rsp_nak === 1'b1) && exp_q.size() > 0)
      chk("answer", 16'(exp_q.pop_front()), 16'({rsp_ack, rsp_nak}));
    tone_p <= chain_tone;
    cyc <= cyc + 1;
    if (chain_tone === 1'b1 && tone_p === 1'b0) begin
      rises <= rises + 1;
      per <= cyc - last_rise;
      last_rise <= cyc;
    end
  end
  // Hang guard, well beyond the some 1300 cycles of the run
  initial begin
    repeat (6000) @(posedge clk_sys);
    err_total++;
    conclude();
  end
  // ======================================
  // Main sequence
  initial begin
    {resetn, is_master, is_top, awake, addr_assigned} = 5'h0F;
    {fault_set, scan_cont_active, cell_scan_active} = 10'h000;
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    cmd(`SCB_CMD_PREFIX, `SCB_ADDR_MASTER, 2'b10);
    cmd(`SCB_CMD_WAKE, `SCB_ADDR_ALL, 2'b10);
    tone_chk(2, 4);
    cmd(`SCB_CMD_PREFIX, 6'h05, 2'b01);
    cmd(`SCB_CMD_PREFIX, `SCB_ADDR_MASTER, 2'b10);
    cmd(`SCB_CMD_CSUM_CALC, `SCB_ADDR_ALL, 2'b01);
    tone_chk(0, 0);
    cmd(`SCB_CMD_PREFIX, `SCB_ADDR_MASTER, 2'b10);
    cmd(`SCB_CMD_WAKE, 6'h05, 2'b01);
    addr_assigned <= 1'b0;
    cmd(`SCB_CMD_PREFIX, `SCB_ADDR_MASTER, 2'b01);
    cmd(`SCB_CMD_WAKE, `SCB_ADDR_ALL, 2'b01);
    addr_assigned <= 1'b1;
    // Manual balance with a random cell pattern
    rs = xs(rs);
    pat = {2'h0, rs[13:1], 1'b1};
    u_host.wr(`SCB_SEL_PATTERN, 4'h0, pat);
    w(`SCB_SEL_SETUP, 16'h0021);
    repeat (4) @(posedge clk_sys);
    chk("setup", 16'h0021, 16'(balance_setup));
    chk("ext drive", pat, 16'(bal_ext_drive));
    w(`SCB_SEL_SETUP, 16'h0061);
    {scan_cont_active, cell_scan_active} <= 2'h3;
    repeat (4) @(posedge clk_sys);
    chk("scan off", 16'h0000, 16'(bal_ext_drive));
    {scan_cont_active, cell_scan_active} <= 2'h0;
    w(`SCB_SEL_SETUP, 16'h0101);
    cmd(`SCB_CMD_BAL_EN, `SCB_ADDR_ALL, 2'h0);
    repeat (4) @(posedge clk_sys);
    chk("enable cmd", 16'h0121, 16'(balance_setup));
    chk("int drive", pat, 16'(bal_int_drive));
    chk("ext idle", 16'h0000, 16'(bal_ext_drive));
    // Timed balance of one 20 s step
    w(`SCB_SEL_SETUP, 16'h0022);
    repeat (450) @(posedge clk_sys);
    chk("no limit", 16'h0001, 16'(balance_setup[5]));
    w(`SCB_SEL_SETUP, 16'h0000);
    w(`SCB_SEL_TIME, 16'h0100);
    w(`SCB_SEL_SETUP, 16'h0022);
    for (k = 0; k < 600 && balance_setup[5] === 1'b1; k++) @(posedge clk_sys);
    chk("timed length", 16'h0001, 16'(k > 390 && k <= 405));
    chk("done bit", 16'h0001, 16'(balance_setup[7]));
    // Checksum store and compare
    cmd(`SCB_CMD_CSUM_CALC, `SCB_ADDR_ALL, 2'h0);
    cmd(`SCB_CMD_CSUM_CHECK, `SCB_ADDR_ALL, 2'h0);
    chk("csum same", 16'h0000, 16'(csum_mismatch));
    u_host.wr(`SCB_SEL_PATTERN, 4'h0, ~pat);
    cmd(`SCB_CMD_CSUM_CHECK, `SCB_ADDR_ALL, 2'h0);
    chk("csum diff", 16'h0001, 16'(csum_mismatch));
    // Fault clear, ignored write and verbatim load
    fault_set <= 8'h41;
    @(posedge clk_sys);
    fault_set <= 8'h00;
    w(`SCB_SEL_FAULT, 16'h0080);
    chk("fault kept", 16'h0041, 16'(fault_reg));
    w(`SCB_SEL_FAULT, 16'h00FF);
    chk("fault clear", 16'h0000, 16'(fault_reg));
    cmd(`SCB_CMD_OVERRIDE, `SCB_ADDR_ALL, 2'h0);
    w(`SCB_SEL_FAULT, 16'h00C3);
    chk("fault load", 16'h00C0, 16'(fault_reg));
    // Soft reset, then roll call again before addressing
    w(`SCB_SEL_SETUP, 16'h0021);
    cmd(`SCB_CMD_SOFTRST, `SCB_ADDR_ALL, 2'h0);
    for (k = 0; k < 40 && soft_reset_done !== 1'b1; k++) @(posedge clk_sys);
    chk("soft done", 16'h0001, 16'(soft_reset_done));
    repeat (2) @(posedge clk_sys);
    chk("soft setup", 16'h0000, 16'(balance_setup));
    chk("soft pattern", 16'h0000, 16'(balance_cell_pattern));
    addr_assigned <= 1'b0;
    @(posedge clk_sys);
    addr_assigned <= 1'b1;
    // Hard reset: wrong address refused, then to all
    cmd(`SCB_CMD_PREFIX, `SCB_ADDR_MASTER, 2'b10);
    cmd(`SCB_CMD_HARDRST, 6'h05, 2'b01);
    cmd(`SCB_CMD_PREFIX, `SCB_ADDR_MASTER, 2'b10);
    cmd(`SCB_CMD_HARDRST, `SCB_ADDR_ALL, 2'h0);
    tone_chk(2, 2);
    chk("hard reset", 16'h0001, 16'(hard_reset_req));
    conclude();
  end
endmodule : scb_ctrl_test

// ---- test/scb_host_model.sv ----
// Purpose: Host side of the command and register port
// Assumes: Requests launched on rising clk_sys
// Notes:   Released fields show inverted data, never stale values
`timescale 1ns/1ps
module scb_host_model (
  input wire logic clk_sys,
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic [5:0] cmd_addr,
  output logic reg_wr,
  output logic [2:0] reg_sel,
  output logic [3:0] reg_idx,
  output logic [15:0] reg_wdata
);
  // ======================================
  // Idle at time zero
  initial begin
    {cmd_valid, cmd_code, cmd_addr} = 15'h0000;
    {reg_wr, reg_sel, reg_idx, reg_wdata} = 24'h000000;
  end
  // One decoded command, held for its taking edge
  task automatic send(input logic [7:0] c, input logic [5:0] a);
    @(posedge clk_sys);
    {cmd_valid, cmd_code, cmd_addr} <= {1'b1, c, a};
    @(posedge clk_sys);
    {cmd_valid, cmd_code, cmd_addr} <= {1'b0, ~c, ~a};
  endtask : send
  // One register write
  task automatic wr(input logic [2:0] s, input logic [3:0] i, input logic [15:0] d);
    @(posedge clk_sys);
    {reg_wr, reg_sel, reg_idx, reg_wdata} <= {1'b1, s, i, d};
    @(posedge clk_sys);
    {reg_wr, reg_sel, reg_idx, reg_wdata} <= {1'b0, ~s, ~i, ~d};
  endtask : wr
endmodule : scb_host_model
